// ==== include/swwc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the sleep and watchdog control.
`ifndef SWWC_DEFS_SVH
`define SWWC_DEFS_SVH
`define SWWC_ADDR_REGULATOR   8'h00
`define SWWC_ADDR_STATUS      8'h01
`define SWWC_ADDR_WATCHDOG    8'h02
`define SWWC_REG_LP_BIT       1
`define SWWC_REG_RSVD_BIT     0
`define SWWC_STAT_TIMEOUT_BIT 4
`define SWWC_STAT_PWRDN_BIT   3
`define SWWC_WD_SWEN_BIT      0
`define SWWC_WD_PS_LSB        1
`define SWWC_WD_PS_MSB        5
`define SWWC_WD_PS_RESET      5'h0B
`define SWWC_WD_PS_MAX        5'h12
`define SWWC_WD_BASE_TICKS    24'h000020
`define SWWC_CLK_HZ           20000000
`define SWWC_CLK_NS           50
`define SWWC_SLOW_HZ          31000
`define SWWC_SLOW_DIV         (`SWWC_CLK_HZ / `SWWC_SLOW_HZ)
`define SWWC_STAB_NS          5000
`define SWWC_STAB_CYC         ((`SWWC_STAB_NS + `SWWC_CLK_NS - 1) / `SWWC_CLK_NS)
`endif

// ==== include/swwc_pkg.sv ====
// Types shared by the sleep, wake and watchdog control.
package swwc_pkg;
	typedef enum logic [2:0] {
		swwc_st_awake = 3'h1,
		swwc_st_sleep = 3'h2,
		swwc_st_stab  = 3'h4
	} swwc_state_t;
	typedef enum logic [1:0] {
		swwc_wd_off   = 2'h0,
		swwc_wd_soft  = 2'h1,
		swwc_wd_awake = 2'h2,
		swwc_wd_on    = 2'h3
	} swwc_wd_mode_t;
	typedef struct packed {
		logic power_on;
		logic brownout_reset;
		logic brownout_enable;
		logic external_reset_pin;
		logic external_reset_enable;
	} swwc_reset_src_t;
	typedef struct packed {
		logic sleep_instr;
		logic watchdog_kick_instruction;
		logic global_interrupt_enable;
	} swwc_cpu_req_t;
	typedef struct packed {
		logic run;
		logic prefetch;
		logic resume;
		logic isr_call;
		logic dev_reset;
	} swwc_cpu_ctl_t;
endpackage

// ==== design/swwc_top.sv ====
// Sleep entry, wake-up, regulator sleep mode and watchdog control.
// Contract
// - Wake on enabled pin reset, brownout, power-on, watchdog, or enabled interrupt.
// - Pin, brownout and power-on wakes reset; watchdog and interrupt wakes resume.
// - Sleep execution prefetches the next instruction.
// - Interrupt wake needs its enable bit, independent of global enable.
// - Wake with global enable clear resumes after sleep, no vector.
// - Wake with global enable set runs next instruction, then vectors.
// - Every wake clears the watchdog counter.
// - Pending enabled interrupt, global enable clear: sleep is a no-op.
// - Interrupt during sleep: complete sleep, wake at once, update flags.
// - Low-power select puts regulator in low power during sleep.
// - Low-power wake inserts stabilisation delay; normal wake is immediate.
// - Peripheral needing normal power overrides low-power sleep.
// - Fast oscillator kept running in sleep when a peripheral requests it.
// - Unregulated variant always sleeps lowest power, no wake delay.
// - Reserved regulator bit reads one; software writes it one.
// - Watchdog expiry without kick resets the device.
// - Watchdog counts slow oscillator ticks; base interval one millisecond.
// - Watchdog period selectable from 1 ms to 256 s.
// - Two-bit mode field selects four watchdog modes.
// - Mode 11 runs the watchdog always, sleep included.
// - Mode 10 runs the watchdog awake only.
// - Mode 01 follows software enable; mode 00 disables.
// - Watchdog expiry in sleep wakes and updates flags, no reset.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "swwc_defs.svh"
module swwc_top
	import swwc_pkg::*;
#(
	parameter logic [11:0] SLOW_DIV   = 12'(`SWWC_SLOW_DIV),
	parameter bit          UNREGULATED = 1'b0
) (
	input  wire logic            clock_in,                 // System clock, 20 MHz.
	input  wire logic            rst_b_in,                 // Asynchronous reset, active low.
	input  wire logic [7:0]      addr_in,                  // Register address.
	input  wire logic [7:0]      wdata_in,                 // Register write data.
	input  wire logic            wr_in,                    // Write strobe.
	input  wire logic            rd_in,                    // Read strobe.
	output logic      [7:0]      rdata_out,                // Read data, cycle after strobe.
	input  wire logic [1:0]      watchdog_mode_field_in,   // Watchdog mode configuration.
	input  wire swwc_reset_src_t reset_src_in,             // Reset sources and enables.
	input  wire swwc_cpu_req_t   cpu_req_in,               // Core instruction strobes.
	input  wire logic [7:0]      irq_flag_in,              // Interrupt flags.
	input  wire logic [7:0]      irq_enable_in,            // Interrupt enables.
	input  wire logic            periph_needs_normal_in,   // Peripheral forbids low-power sleep.
	input  wire logic            fast_osc_request_in,      // Peripheral uses the fast oscillator.
	output swwc_cpu_ctl_t        cpu_ctl_out,              // Core clock and sequencing.
	output logic                 regulator_lowpower_out,   // Regulator in low-power state.
	output logic                 fast_osc_keep_out,        // Fast oscillator kept in sleep.
	output logic                 watchdog_running_out      // Watchdog is counting.
);
	localparam logic [6:0] STAB_CYC = 7'(`SWWC_STAB_CYC);

	swwc_state_t   state_q;
	swwc_state_t   state_d;
	swwc_wd_mode_t wd_mode;
	logic [11:0]   div_q;
	logic [22:0]   wd_cnt_q;
	logic [22:0]   wd_last;
	logic [4:0]    wd_ps_q;
	logic [4:0]    wd_ps_eff;
	logic          wd_swen_q;
	logic          reg_lp_sel_q;
	logic          timeout_flag_n_q;
	logic          powerdown_flag_n_q;
	logic [6:0]    stab_cnt_q;
	logic          wake_irq_q;
	logic          run_q;
	logic          prefetch_q;
	logic          resume_q;
	logic          isr_call_q;
	logic          dev_reset_q;
	logic          reg_lp_q;
	logic          fast_keep_q;
	logic          wd_run_q;
	logic [7:0]    rdata_q;
	logic          slow_tick;
	logic          wake_req;
	logic          reset_ev;
	logic          wd_on;
	logic          wd_hit;
	logic          sleep_req;
	logic          sleep_noop;
	logic          sleep_go;
	logic          sleep_wake;
	logic          lp_mode;
	logic          need_stab;
	logic          go_awake;

	assign wake_req = |(irq_flag_in & irq_enable_in);
	assign reset_ev = reset_src_in.power_on
		| (reset_src_in.brownout_reset & reset_src_in.brownout_enable)
		| (reset_src_in.external_reset_pin & reset_src_in.external_reset_enable);
	assign sleep_req = (state_q == swwc_st_awake) & cpu_req_in.sleep_instr & ~reset_ev & ~wd_hit;
	assign sleep_noop = sleep_req & ~cpu_req_in.global_interrupt_enable & wake_req;
	assign sleep_go = sleep_req & ~sleep_noop;
	assign sleep_wake = (state_q == swwc_st_sleep) & ~reset_ev & (wake_req | wd_hit);
	assign lp_mode = UNREGULATED | (reg_lp_sel_q & ~periph_needs_normal_in);
	assign need_stab = ~UNREGULATED & reg_lp_sel_q & ~periph_needs_normal_in;
	assign go_awake = (state_q != swwc_st_awake) & (state_d == swwc_st_awake) & ~reset_ev;

	// Slow oscillator time base; one enable pulse per nominal 31 kHz period.
	assign slow_tick = (div_q == 12'h000);
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_q <= 12'h000;
		end else if (slow_tick) begin
			div_q <= SLOW_DIV - 12'h001;
		end else begin
			div_q <= div_q - 12'h001;
		end
	end

	// The slow divider is never reset by sleep, so the watchdog keeps its own time base.
	always_comb begin
		wd_mode = swwc_wd_mode_t'(watchdog_mode_field_in);
		case (wd_mode)
			swwc_wd_on:    wd_on = 1'b1;
			swwc_wd_awake: wd_on = (state_q == swwc_st_awake);
			swwc_wd_soft:  wd_on = wd_swen_q;
			swwc_wd_off:   wd_on = 1'b0;
			default:       wd_on = 1'b0;
		endcase
	end

	// Reserved period codes behave as the shortest interval.
	assign wd_ps_eff = (wd_ps_q > `SWWC_WD_PS_MAX) ? 5'h00 : wd_ps_q;
	assign wd_last = 23'((`SWWC_WD_BASE_TICKS << wd_ps_eff) - 24'h000001);
	assign wd_hit = wd_on & slow_tick & (wd_cnt_q == wd_last) & ~reset_ev;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wd_cnt_q <= 23'h000000;
		end else if (reset_ev || cpu_req_in.watchdog_kick_instruction || !wd_on
				|| sleep_go || sleep_wake || wd_hit) begin
			wd_cnt_q <= 23'h000000;
		end else if (slow_tick) begin
			wd_cnt_q <= wd_cnt_q + 23'h000001;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			swwc_st_awake: begin
				if (sleep_go) begin
					state_d = swwc_st_sleep;
				end
			end
			swwc_st_sleep: begin
				if (reset_ev) begin
					state_d = swwc_st_awake;
				end else if (sleep_wake) begin
					state_d = need_stab ? swwc_st_stab : swwc_st_awake;
				end
			end
			swwc_st_stab: begin
				if (reset_ev || stab_cnt_q == 7'h00) begin
					state_d = swwc_st_awake;
				end
			end
			default: state_d = swwc_st_awake;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= swwc_st_awake;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stab_cnt_q <= 7'h00;
		end else if (sleep_wake) begin
			stab_cnt_q <= STAB_CYC - 7'h01;
		end else if (stab_cnt_q != 7'h00) begin
			stab_cnt_q <= stab_cnt_q - 7'h01;
		end
	end

	// The wake cause is held so the vector decision survives the stabilisation delay.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wake_irq_q <= 1'b0;
		end else if (sleep_wake) begin
			wake_irq_q <= wake_req;
		end
	end

	// Flags are active low; pin reset leaves them alone.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			timeout_flag_n_q   <= 1'b1;
			powerdown_flag_n_q <= 1'b1;
		end else if (reset_src_in.power_on
				|| (reset_src_in.brownout_reset && reset_src_in.brownout_enable)) begin
			timeout_flag_n_q   <= 1'b1;
			powerdown_flag_n_q <= 1'b1;
		end else if (reset_ev) begin
			timeout_flag_n_q   <= timeout_flag_n_q;
		end else if (wd_hit) begin
			timeout_flag_n_q   <= 1'b0;
		end else if (sleep_go) begin
			timeout_flag_n_q   <= 1'b1;
			powerdown_flag_n_q <= 1'b0;
		end else if (cpu_req_in.watchdog_kick_instruction) begin
			timeout_flag_n_q   <= 1'b1;
			powerdown_flag_n_q <= 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_q       <= 1'b1;
			prefetch_q  <= 1'b0;
			resume_q    <= 1'b0;
			isr_call_q  <= 1'b0;
			dev_reset_q <= 1'b0;
		end else begin
			run_q       <= (state_d == swwc_st_awake);
			prefetch_q  <= sleep_req;
			resume_q    <= go_awake;
			isr_call_q  <= go_awake & (state_q == swwc_st_stab ? wake_irq_q : wake_req)
				& cpu_req_in.global_interrupt_enable;
			dev_reset_q <= reset_ev | (wd_hit & (state_q == swwc_st_awake));
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_lp_q    <= 1'b0;
			fast_keep_q <= 1'b0;
			wd_run_q    <= 1'b0;
		end else begin
			reg_lp_q    <= (state_d == swwc_st_sleep) & lp_mode;
			fast_keep_q <= (state_d == swwc_st_sleep) & fast_osc_request_in;
			wd_run_q    <= wd_on;
		end
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_lp_sel_q <= 1'b0;
			wd_ps_q      <= `SWWC_WD_PS_RESET;
			wd_swen_q    <= 1'b0;
		end else if (wr_in) begin
			case (addr_in)
				`SWWC_ADDR_REGULATOR: begin
					reg_lp_sel_q <= wdata_in[`SWWC_REG_LP_BIT] & ~UNREGULATED;
				end
				`SWWC_ADDR_WATCHDOG: begin
					wd_ps_q   <= wdata_in[`SWWC_WD_PS_MSB:`SWWC_WD_PS_LSB];
					wd_swen_q <= wdata_in[`SWWC_WD_SWEN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Unmapped reads return zero; the status flags are read only.
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_q <= 8'h00;
		end else if (rd_in) begin
			rdata_q <= 8'h00;
			case (addr_in)
				`SWWC_ADDR_REGULATOR: begin
					rdata_q[`SWWC_REG_LP_BIT]   <= reg_lp_sel_q;
					rdata_q[`SWWC_REG_RSVD_BIT] <= 1'b1;
				end
				`SWWC_ADDR_STATUS: begin
					rdata_q[`SWWC_STAT_TIMEOUT_BIT] <= timeout_flag_n_q;
					rdata_q[`SWWC_STAT_PWRDN_BIT]   <= powerdown_flag_n_q;
				end
				`SWWC_ADDR_WATCHDOG: begin
					rdata_q[`SWWC_WD_PS_MSB:`SWWC_WD_PS_LSB] <= wd_ps_q;
					rdata_q[`SWWC_WD_SWEN_BIT]               <= wd_swen_q;
				end
				default: begin
				end
			endcase
		end
	end

	assign rdata_out              = rdata_q;
	assign cpu_ctl_out            = {run_q, prefetch_q, resume_q, isr_call_q, dev_reset_q};
	assign regulator_lowpower_out = reg_lp_q;
	assign fast_osc_keep_out      = fast_keep_q;
	assign watchdog_running_out   = wd_run_q;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	AST_WAKE_SOURCES: assert property ((state_q == swwc_st_sleep) && reset_ev |=>
		(state_q == swwc_st_awake) && dev_reset_q)
		else $error("Reset event in sleep did not reset the device.");
	AST_IRQ_RESUME: assert property ((state_q == swwc_st_sleep) && wake_req && !reset_ev
		&& !need_stab |=> resume_q && run_q && !dev_reset_q)
		else $error("Interrupt wake did not resume execution.");
	AST_PREFETCH: assert property (sleep_req |=> prefetch_q)
		else $error("Sleep execution did not prefetch the next instruction.");
	AST_NOOP: assert property (sleep_noop |=> (state_q == swwc_st_awake) && run_q
		&& $stable(powerdown_flag_n_q) && $stable(timeout_flag_n_q))
		else $error("Sleep with pending interrupt was not a no-op.");
	AST_SLEEP_FLAGS: assert property (sleep_go |=> (state_q == swwc_st_sleep)
		&& !powerdown_flag_n_q && timeout_flag_n_q && !run_q && wd_cnt_q == 23'h000000)
		else $error("Sleep entry did not update flags and watchdog.");
	AST_WAKE_CLEARS: assert property (sleep_wake |=> wd_cnt_q == 23'h000000)
		else $error("Wake did not clear the watchdog.");
	AST_NO_VECTOR: assert property (go_awake && !cpu_req_in.global_interrupt_enable
		|=> !isr_call_q)
		else $error("Vector taken with global enable clear.");
	AST_STAB_DELAY: assert property (sleep_wake && need_stab |=> !run_q [*8])
		else $error("Low-power wake skipped the stabilisation delay.");
	AST_LOWPOWER: assert property ((state_q == swwc_st_sleep) && $past(state_q == swwc_st_sleep)
		&& (lp_mode == $past(lp_mode)) |-> reg_lp_q == lp_mode)
		else $error("Regulator mode differs from selection during sleep.");
	AST_MODE10: assert property ((wd_mode == swwc_wd_awake) && (state_q == swwc_st_sleep)
		|=> (state_q != swwc_st_sleep) || wd_cnt_q == 23'h000000)
		else $error("Watchdog counted during sleep in awake-only mode.");
	AST_WD_RESET: assert property (wd_hit && (state_q == swwc_st_awake) |=> dev_reset_q
		&& !timeout_flag_n_q)
		else $error("Watchdog expiry did not reset the device.");
	AST_WD_SLEEP: assert property (wd_hit && (state_q == swwc_st_sleep) |=> !dev_reset_q
		&& !timeout_flag_n_q && !powerdown_flag_n_q)
		else $error("Watchdog expiry in sleep reset the device.");
	AST_RSVD_ONE: assert property (rd_in && addr_in == `SWWC_ADDR_REGULATOR |=> rdata_out[0])
		else $error("Reserved regulator bit read as zero.");

	COV_NOOP: cover property (sleep_noop);
	COV_STAB_WAKE: cover property ((state_q == swwc_st_stab) ##1 (state_q == swwc_st_awake));
	COV_WD_WAKE: cover property (wd_hit && (state_q == swwc_st_sleep));
	COV_ISR_WAKE: cover property (isr_call_q);
endmodule
`default_nettype wire

// ==== verification/swwc_core_model.sv ====
// Behavioural core and interrupt sources on the far side of the sleep control.
`timescale 1ns/1ns
`default_nettype none
module swwc_core_model
	import swwc_pkg::*;
(
	input  wire logic          clock_in,        // System clock.
	input  wire swwc_cpu_ctl_t cpu_ctl_in,      // Sequencing from the sleep control.
	output swwc_cpu_req_t      cpu_req_out,     // Instruction strobes and global enable.
	output logic [7:0]         irq_flag_out,    // Interrupt flags.
	output logic [7:0]         irq_enable_out   // Interrupt enables.
);
	int resumes;
	initial begin
		cpu_req_out = '0;
		irq_flag_out = 8'h00;
		irq_enable_out = 8'h00;
		resumes = 0;
	end
	// The word after sleep is a no-operation, so a resume runs nothing harmful.
	always @(posedge clock_in) begin
		if (cpu_ctl_in.resume === 1'b1) begin
			resumes <= resumes + 1;
		end
		// A device reset clears the global and per-source enables, as a real core would.
		if (cpu_ctl_in.dev_reset === 1'b1) begin
			cpu_req_out.global_interrupt_enable <= 1'b0;
			irq_enable_out <= 8'h00;
		end
	end
	task automatic sleep_op();
		@(posedge clock_in);
		cpu_req_out.sleep_instr <= 1'b1;
		@(posedge clock_in);
		cpu_req_out.sleep_instr <= 1'b0;
	endtask
	task automatic kick();
		@(posedge clock_in);
		cpu_req_out.watchdog_kick_instruction <= 1'b1;
		@(posedge clock_in);
		cpu_req_out.watchdog_kick_instruction <= 1'b0;
	endtask
	task automatic set_gie(input logic g);
		@(posedge clock_in);
		cpu_req_out.global_interrupt_enable <= g;
	endtask
	task automatic set_irq(input logic [7:0] f, input logic [7:0] e);
		@(posedge clock_in);
		irq_flag_out <= f;
		irq_enable_out <= e;
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the sleep, wake and watchdog control.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import swwc_pkg::*;
;
	localparam int RUN = 4;
	localparam int PRE = 3;
	localparam int RES = 2;
	localparam int ISR = 1;
	localparam int DRST = 0;
	logic            clock_in;
	logic            rst_b_in;
	logic [7:0]      addr_in;
	logic [7:0]      wdata_in;
	logic            wr_in;
	logic            rd_in;
	logic [7:0]      rdata_out;
	logic [1:0]      watchdog_mode_field_in;
	swwc_reset_src_t reset_src_in;
	swwc_cpu_req_t   cpu_req_in;
	logic [7:0]      irq_flag_in;
	logic [7:0]      irq_enable_in;
	logic            periph_needs_normal_in;
	logic            fast_osc_request_in;
	swwc_cpu_ctl_t   cpu_ctl_out;
	logic            regulator_lowpower_out;
	logic            fast_osc_keep_out;
	logic            watchdog_running_out;
	int              n_errors;
	int              n_tests;
	int              n;
	logic [7:0]      d;
	swwc_core_model core (.clock_in, .cpu_ctl_in(cpu_ctl_out), .cpu_req_out(cpu_req_in),
		.irq_flag_out(irq_flag_in), .irq_enable_out(irq_enable_in));
	// A short slow-tick divider keeps each watchdog expiry near 128 cycles.
	swwc_top #(.SLOW_DIV(12'h004), .UNREGULATED(1'b0)) dut (.clock_in, .rst_b_in, .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .watchdog_mode_field_in, .reset_src_in,
		.cpu_req_in, .irq_flag_in, .irq_enable_in, .periph_needs_normal_in,
		.fast_osc_request_in, .cpu_ctl_out, .regulator_lowpower_out, .fast_osc_keep_out,
		.watchdog_running_out);
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	task automatic results();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	// Counts cycles until the chosen sequencing bit is high, giving up at the limit.
	task automatic wait_ctl(input int b, input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim && cpu_ctl_out[b] !== 1'b1) begin
			@(posedge clock_in);
			#1 cnt++;
		end
	endtask
	initial begin
		#400000;
		n_errors++;
		results();
	end
	initial begin
		rst_b_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		watchdog_mode_field_in = 2'h0;
		reset_src_in = '0;
		periph_needs_normal_in = 1'b0;
		fast_osc_request_in = 1'b0;
		n_errors = 0;
		n_tests = 0;
		repeat (12) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rd(8'h00, d);
		chk("regulator", d, 8'h01);
		rd(8'h01, d);
		chk("status", d, 8'h18);
		rd(8'h02, d);
		chk("watchdog_ctl", d, 8'h16);
		rd(8'h03, d);
		chk("unmapped", d, 8'h00);
		wr(8'h00, 8'h01);
		rd(8'h00, d);
		chk("reserved_bit", d, 8'h01);
		wr(8'h01, 8'h00);
		rd(8'h01, d);
		chk("status_ro", d, 8'h18);
		wr(8'h02, 8'h00);
		core.set_irq(8'h04, 8'h00);
		core.sleep_op();
		#1 chk("prefetch", 8'(cpu_ctl_out[PRE]), 8'h01);
		chk("run_off", 8'(cpu_ctl_out[RUN]), 8'h00);
		wait_ctl(RES, 30, n);
		chk("masked_wake", 8'(n), 8'h1E);
		core.set_irq(8'h04, 8'h04);
		wait_ctl(RES, 6, n);
		chk("irq_wake", 8'(n < 6), 8'h01);
		chk("isr_gie_off", 8'(cpu_ctl_out[ISR]), 8'h00);
		core.set_irq(8'h00, 8'h00);
		rd(8'h01, d);
		chk("status_slept", d, 8'h10);
		core.set_gie(1'b1);
		core.sleep_op();
		core.set_irq(8'h01, 8'h01);
		wait_ctl(RES, 6, n);
		chk("isr_gie_on", 8'(cpu_ctl_out[ISR]), 8'h01);
		core.set_irq(8'h00, 8'h00);
		core.kick();
		core.set_gie(1'b0);
		core.set_irq(8'h02, 8'h02);
		core.sleep_op();
		#1 chk("noop_run", 8'(cpu_ctl_out[RUN]), 8'h01);
		core.set_irq(8'h00, 8'h00);
		rd(8'h01, d);
		chk("noop_status", d, 8'h18);
		wr(8'h00, 8'h03);
		rd(8'h00, d);
		chk("lp_select", d, 8'h03);
		core.sleep_op();
		repeat (2) @(posedge clock_in);
		#1 chk("lp_state", 8'(regulator_lowpower_out), 8'h01);
		core.set_irq(8'h01, 8'h01);
		wait_ctl(RES, 150, n);
		chk("lp_wake_delay", 8'(n >= 99 && n < 150), 8'h01);
		core.set_irq(8'h00, 8'h00);
		periph_needs_normal_in <= 1'b1;
		fast_osc_request_in <= 1'b1;
		core.sleep_op();
		repeat (2) @(posedge clock_in);
		#1 chk("lp_override", 8'(regulator_lowpower_out), 8'h00);
		chk("fast_keep", 8'(fast_osc_keep_out), 8'h01);
		core.set_irq(8'h01, 8'h01);
		wait_ctl(RES, 10, n);
		chk("quick_wake", 8'(n < 10), 8'h01);
		core.set_irq(8'h00, 8'h00);
		periph_needs_normal_in <= 1'b0;
		fast_osc_request_in <= 1'b0;
		wr(8'h00, 8'h01);
		core.sleep_op();
		reset_src_in.external_reset_pin <= 1'b1;
		wait_ctl(DRST, 20, n);
		chk("pin_disabled", 8'(n), 8'h14);
		@(posedge clock_in);
		reset_src_in.external_reset_enable <= 1'b1;
		wait_ctl(DRST, 6, n);
		chk("pin_reset", 8'(n < 6), 8'h01);
		chk("pin_no_resume", 8'(cpu_ctl_out[RES]), 8'h00);
		@(posedge clock_in);
		reset_src_in <= '0;
		wr(8'h02, 8'h00);
		core.kick();
		watchdog_mode_field_in <= 2'h3;
		wait_ctl(DRST, 300, n);
		chk("wd_expiry", 8'(n >= 100 && n <= 200), 8'h01);
		chk("wd_running", 8'(watchdog_running_out), 8'h01);
		wr(8'h02, 8'h00);
		rd(8'h01, d);
		chk("wd_timeout_flag", d & 8'h10, 8'h00);
		core.sleep_op();
		wait_ctl(RES, 200, n);
		chk("wd_sleep_wake", 8'(n < 200), 8'h01);
		chk("wd_no_reset", 8'(cpu_ctl_out[DRST]), 8'h00);
		@(posedge clock_in);
		watchdog_mode_field_in <= 2'h2;
		rd(8'h01, d);
		chk("wd_wake_status", d, 8'h00);
		core.sleep_op();
		wait_ctl(RES, 300, n);
		chk("wd_off_asleep", 8'(n == 300), 8'h01);
		chk("wd_stopped", 8'(watchdog_running_out), 8'h00);
		core.set_irq(8'h01, 8'h01);
		wait_ctl(RES, 6, n);
		core.set_irq(8'h00, 8'h00);
		#1 chk("wd_awake_run", 8'(watchdog_running_out), 8'h01);
		@(posedge clock_in);
		watchdog_mode_field_in <= 2'h1;
		wr(8'h02, 8'h01);
		repeat (2) @(posedge clock_in);
		#1 chk("wd_soft_on", 8'(watchdog_running_out), 8'h01);
		wr(8'h02, 8'h00);
		repeat (2) @(posedge clock_in);
		#1 chk("wd_soft_off", 8'(watchdog_running_out), 8'h00);
		@(posedge clock_in);
		watchdog_mode_field_in <= 2'h0;
		wr(8'h02, 8'h01);
		repeat (2) @(posedge clock_in);
		#1 chk("wd_mode_off", 8'(watchdog_running_out), 8'h00);
		// A brownout in sleep must reset the device and set both status flags.
		core.sleep_op();
		reset_src_in.brownout_reset <= 1'b1;
		reset_src_in.brownout_enable <= 1'b1;
		wait_ctl(DRST, 6, n);
		chk("bor_wake", 8'(n < 6), 8'h01);
		chk("bor_no_resume", 8'(cpu_ctl_out[RES]), 8'h00);
		@(posedge clock_in);
		reset_src_in <= '0;
		rd(8'h01, d);
		chk("bor_flags", d, 8'h18);
		chk("resume_count", 8'(core.resumes), 8'h06);
		results();
	end
endmodule
`default_nettype wire
